// File: dcc_consts.svh
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

// ==================================================
// register offsets
`define DCC_ADDR_CH1_VOUT     8'h03
`define DCC_ADDR_CH1_IOUT     8'h04
`define DCC_ADDR_CH1_CMPM     8'h05
`define DCC_ADDR_CH0_VOUT     8'h15
`define DCC_ADDR_CH0_IOUT     8'h16
`define DCC_ADDR_CH0_CMPM     8'h17

// ==================================================
// reset values and writable bit masks
`define DCC_REG_RESET         16'h0000
`define DCC_VOUT_MASK         16'h1C1F
`define DCC_IOUT_MASK         16'h1E00
`define DCC_CMPM_MASK         16'h0C00

// ==================================================
// field positions
`define DCC_GAIN_LSB          10
`define DCC_GAIN_MSB          12
`define DCC_OD_BIT            4
`define DCC_ROUTE_BIT         3
`define DCC_HIZ_DIS_BIT       2
`define DCC_INV_BIT           1
`define DCC_EN_BIT            0
`define DCC_IRANGE_LSB        9
`define DCC_IRANGE_MSB        12
`define DCC_CMODE_LSB         10
`define DCC_CMODE_MSB         11
`define DCC_MARGIN_MSB        15

`endif

// File: dcc_pkg.sv
package dcc_pkg;

    // ==================================================
    // register kinds, one-hot
    typedef enum logic [3:0] {
        DCC_KIND_NONE = 4'h1,
        DCC_KIND_VOUT = 4'h2,
        DCC_KIND_IOUT = 4'h4,
        DCC_KIND_CMPM = 4'h8
    } dcc_kind_e;

    // ==================================================
    // reference source, one-hot, all zero for none
    typedef enum logic [2:0] {
        DCC_REF_NONE = 3'h0,
        DCC_REF_EXT  = 3'h1,
        DCC_REF_VDD  = 3'h2,
        DCC_REF_INT  = 3'h4
    } dcc_ref_e;

    // ==================================================
    // comparator threshold mode and hysteresis state
    typedef enum logic [1:0] {
        DCC_CMODE_SINGLE = 2'h0,
        DCC_CMODE_HYST   = 2'h1,
        DCC_CMODE_WINDOW = 2'h2,
        DCC_CMODE_BAD    = 2'h3
    } dcc_cmode_e;

    typedef enum logic [1:0] {
        DCC_ST_LOW  = 2'h1,
        DCC_ST_HIGH = 2'h2
    } dcc_cmp_state_e;

    typedef struct packed {
        logic      hit;
        logic      ch;
        dcc_kind_e kind;
    } dcc_addr_s;

    typedef struct packed {
        dcc_ref_e   ref_sel;
        logic [3:0] gain_x2;
        logic       gain_bad;
        logic [3:0] irange;
        logic       irange_bad;
        logic       cmp_en;
        logic       fb_div_en;
        logic       hyst_en;
        logic       window_en;
        logic       cmode_bad;
        logic       pin_o;
        logic       pin_oe;
        logic       open_drain;
        logic       analog_en;
    } dcc_chan_out_s;

endpackage : dcc_pkg

// File: dcc_cmp_if.sv
`timescale 1ns/1ps

interface dcc_cmp_if #(
    parameter int CODE_W = 12
);
    logic              en;
    logic              inv;
    logic [1:0]        mode;
    logic [CODE_W-1:0] thr_hi;
    logic [CODE_W-1:0] thr_lo;
    logic [CODE_W-1:0] ref_code;
    logic [CODE_W-1:0] fb_code;
    logic              result;

    modport ctl (output en, inv, mode, thr_hi, thr_lo, ref_code, fb_code, input result);
    modport cmp (input en, inv, mode, thr_hi, thr_lo, ref_code, fb_code, output result);
endinterface : dcc_cmp_if

// File: dcc_chan_cmp.sv
`timescale 1ns/1ps

module dcc_chan_cmp (
    input  wire logic  i_sys_clk,
    input  wire logic  i_srst,
    dcc_cmp_if.cmp     cif
);

    dcc_pkg::dcc_cmp_state_e state_ff;
    dcc_pkg::dcc_cmp_state_e nxt_state;
    logic                    result_ff;
    logic                    nxt_result;
    logic                    raw;

    // ==================================================
    // threshold decision
    always_comb begin
        nxt_state = state_ff;
        raw       = 1'b0;
        case (dcc_pkg::dcc_cmode_e'(cif.mode))
            dcc_pkg::DCC_CMODE_HYST: begin
                if (cif.fb_code > cif.thr_hi) begin
                    nxt_state = dcc_pkg::DCC_ST_HIGH;
                end else if (cif.fb_code < cif.thr_lo) begin
                    nxt_state = dcc_pkg::DCC_ST_LOW;
                end
                raw = (nxt_state == dcc_pkg::DCC_ST_HIGH);
            end
            dcc_pkg::DCC_CMODE_WINDOW: begin
                raw = (cif.fb_code >= cif.thr_lo) && (cif.fb_code <= cif.thr_hi);
            end
            default: begin
                raw = (cif.fb_code > cif.ref_code);
            end
        endcase
        if (!cif.en) begin
            nxt_state = dcc_pkg::DCC_ST_LOW;
        end
        nxt_result = cif.en & (raw ^ cif.inv);
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            state_ff  <= dcc_pkg::DCC_ST_LOW;
            result_ff <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            result_ff <= nxt_result;
        end
    end

    assign cif.result = result_ff;

endmodule : dcc_chan_cmp

// File: dcc_config_top.sv
`timescale 1ns/1ps
`include "dcc_consts.svh"

module dcc_config_top #(
    parameter int CODE_W = 12
) (
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_srst,
    input  wire logic                   i_reg_wr,
    input  wire logic                   i_reg_rd,
    input  wire logic [7:0]             i_reg_addr,
    input  wire logic [15:0]            i_reg_wdata,
    output logic      [15:0]            o_reg_rdata,
    output logic                        o_reg_ack,
    output logic                        o_reg_hit,
    input  wire logic [1:0][15:0]       i_margin_high,
    input  wire logic [1:0][15:0]       i_margin_low,
    input  wire logic [1:0][CODE_W-1:0] i_dac_code,
    input  wire logic [1:0][CODE_W-1:0] i_fb_code,
    output logic      [1:0][2:0]        o_ref_sel,
    output logic      [1:0][3:0]        o_gain_x2,
    output logic      [1:0]             o_gain_invalid,
    output logic      [1:0][3:0]        o_iout_range,
    output logic      [1:0]             o_iout_invalid,
    output logic      [1:0]             o_cmp_mode_en,
    output logic      [1:0]             o_fb_divider_en,
    output logic      [1:0]             o_hyst_en,
    output logic      [1:0]             o_window_en,
    output logic      [1:0]             o_cmp_mode_invalid,
    output logic      [1:0]             o_cmp_result,
    output logic      [1:0]             o_out_pin_o,
    output logic      [1:0]             o_out_pin_oe,
    output logic      [1:0]             o_out_open_drain,
    output logic      [1:0]             o_out_analog_en
);

    // ==================================================
    // address decode, shared by read and write
    function automatic dcc_pkg::dcc_addr_s dcc_decode(input logic [7:0] addr);
        dcc_pkg::dcc_addr_s d;
        d.hit  = 1'b1;
        d.ch   = 1'b0;
        d.kind = dcc_pkg::DCC_KIND_NONE;
        case (addr)
            `DCC_ADDR_CH0_VOUT: begin
                d.kind = dcc_pkg::DCC_KIND_VOUT;
            end
            `DCC_ADDR_CH0_IOUT: begin
                d.kind = dcc_pkg::DCC_KIND_IOUT;
            end
            `DCC_ADDR_CH0_CMPM: begin
                d.kind = dcc_pkg::DCC_KIND_CMPM;
            end
            `DCC_ADDR_CH1_VOUT: begin
                d.ch   = 1'b1;
                d.kind = dcc_pkg::DCC_KIND_VOUT;
            end
            `DCC_ADDR_CH1_IOUT: begin
                d.ch   = 1'b1;
                d.kind = dcc_pkg::DCC_KIND_IOUT;
            end
            `DCC_ADDR_CH1_CMPM: begin
                d.ch   = 1'b1;
                d.kind = dcc_pkg::DCC_KIND_CMPM;
            end
            default: begin
                d.hit = 1'b0;
            end
        endcase
        return d;
    endfunction : dcc_decode

    // ==================================================
    // configuration registers
    logic [1:0][15:0]   vout_ff;
    logic [1:0][15:0]   iout_ff;
    logic [1:0][15:0]   cmpm_ff;
    logic [1:0][15:0]   nxt_vout;
    logic [1:0][15:0]   nxt_iout;
    logic [1:0][15:0]   nxt_cmpm;
    logic [15:0]        rdata_ff;
    logic [15:0]        nxt_rdata;
    logic               ack_ff;
    logic               nxt_ack;
    logic               hit_ff;
    logic               nxt_hit;
    dcc_pkg::dcc_addr_s dec;

    assign dec = dcc_decode(i_reg_addr);

    always_comb begin
        nxt_vout  = vout_ff;
        nxt_iout  = iout_ff;
        nxt_cmpm  = cmpm_ff;
        nxt_rdata = 16'h0000;
        nxt_ack   = i_reg_rd | i_reg_wr;
        nxt_hit   = (i_reg_rd | i_reg_wr) & dec.hit;
        if (i_reg_wr && dec.hit) begin
            case (dec.kind)
                dcc_pkg::DCC_KIND_VOUT: begin
                    nxt_vout[dec.ch] = i_reg_wdata & `DCC_VOUT_MASK;
                end
                dcc_pkg::DCC_KIND_IOUT: begin
                    nxt_iout[dec.ch] = i_reg_wdata & `DCC_IOUT_MASK;
                end
                dcc_pkg::DCC_KIND_CMPM: begin
                    nxt_cmpm[dec.ch] = i_reg_wdata & `DCC_CMPM_MASK;
                end
                default: begin
                    nxt_vout = vout_ff;
                end
            endcase
        end else if (i_reg_rd && dec.hit) begin
            case (dec.kind)
                dcc_pkg::DCC_KIND_VOUT: begin
                    nxt_rdata = vout_ff[dec.ch];
                end
                dcc_pkg::DCC_KIND_IOUT: begin
                    nxt_rdata = iout_ff[dec.ch];
                end
                dcc_pkg::DCC_KIND_CMPM: begin
                    nxt_rdata = cmpm_ff[dec.ch];
                end
                default: begin
                    nxt_rdata = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            vout_ff  <= {2{`DCC_REG_RESET}};
            iout_ff  <= {2{`DCC_REG_RESET}};
            cmpm_ff  <= {2{`DCC_REG_RESET}};
            rdata_ff <= 16'h0000;
            ack_ff   <= 1'b0;
            hit_ff   <= 1'b0;
        end else begin
            vout_ff  <= nxt_vout;
            iout_ff  <= nxt_iout;
            cmpm_ff  <= nxt_cmpm;
            rdata_ff <= nxt_rdata;
            ack_ff   <= nxt_ack;
            hit_ff   <= nxt_hit;
        end
    end

    assign o_reg_rdata = rdata_ff;
    assign o_reg_ack   = ack_ff;
    assign o_reg_hit   = hit_ff;

    // ==================================================
    // per channel decode, comparator and pin control
    dcc_pkg::dcc_chan_out_s [1:0] out_ff;
    dcc_pkg::dcc_chan_out_s [1:0] nxt_out;

    generate
        for (genvar g = 0; g < 2; g++) begin : g_chan
            dcc_cmp_if #(.CODE_W(CODE_W)) cif ();
            logic cmp_en;
            logic pin_route;

            assign cmp_en       = vout_ff[g][`DCC_EN_BIT];
            assign pin_route    = vout_ff[g][`DCC_ROUTE_BIT];
            assign cif.en       = cmp_en;
            assign cif.inv      = vout_ff[g][`DCC_INV_BIT];
            assign cif.mode     = cmpm_ff[g][`DCC_CMODE_MSB:`DCC_CMODE_LSB];
            assign cif.thr_hi   = i_margin_high[g][`DCC_MARGIN_MSB -: CODE_W];
            assign cif.thr_lo   = i_margin_low[g][`DCC_MARGIN_MSB -: CODE_W];
            assign cif.ref_code = i_dac_code[g];
            assign cif.fb_code  = i_fb_code[g];

            dcc_chan_cmp u_cmp (
                .i_sys_clk (i_sys_clk),
                .i_srst    (i_srst),
                .cif       (cif.cmp)
            );

            always_comb begin
                nxt_out[g]            = '0;
                nxt_out[g].ref_sel    = dcc_pkg::DCC_REF_NONE;
                case (vout_ff[g][`DCC_GAIN_MSB:`DCC_GAIN_LSB])
                    3'h0: begin
                        nxt_out[g].ref_sel = dcc_pkg::DCC_REF_EXT;
                        nxt_out[g].gain_x2 = 4'h2;
                    end
                    3'h1: begin
                        nxt_out[g].ref_sel = dcc_pkg::DCC_REF_VDD;
                        nxt_out[g].gain_x2 = 4'h2;
                    end
                    3'h2: begin
                        nxt_out[g].ref_sel = dcc_pkg::DCC_REF_INT;
                        nxt_out[g].gain_x2 = 4'h3;
                    end
                    3'h3: begin
                        nxt_out[g].ref_sel = dcc_pkg::DCC_REF_INT;
                        nxt_out[g].gain_x2 = 4'h4;
                    end
                    3'h4: begin
                        nxt_out[g].ref_sel = dcc_pkg::DCC_REF_INT;
                        nxt_out[g].gain_x2 = 4'h6;
                    end
                    3'h5: begin
                        nxt_out[g].ref_sel = dcc_pkg::DCC_REF_INT;
                        nxt_out[g].gain_x2 = 4'h8;
                    end
                    default: begin
                        nxt_out[g].gain_bad = 1'b1;
                    end
                endcase
                case (iout_ff[g][`DCC_IRANGE_MSB:`DCC_IRANGE_LSB])
                    4'h8: begin
                        nxt_out[g].irange = 4'h1;
                    end
                    4'h9: begin
                        nxt_out[g].irange = 4'h2;
                    end
                    4'hA: begin
                        nxt_out[g].irange = 4'h4;
                    end
                    4'hB: begin
                        nxt_out[g].irange = 4'h8;
                    end
                    default: begin
                        nxt_out[g].irange_bad = 1'b1;
                    end
                endcase
                case (dcc_pkg::dcc_cmode_e'(cif.mode))
                    dcc_pkg::DCC_CMODE_HYST: begin
                        nxt_out[g].hyst_en = 1'b1;
                    end
                    dcc_pkg::DCC_CMODE_WINDOW: begin
                        nxt_out[g].window_en = 1'b1;
                    end
                    dcc_pkg::DCC_CMODE_BAD: begin
                        nxt_out[g].cmode_bad = 1'b1;
                    end
                    default: begin
                        nxt_out[g].hyst_en = 1'b0;
                    end
                endcase
                nxt_out[g].cmp_en    = cmp_en;
                nxt_out[g].fb_div_en = vout_ff[g][`DCC_HIZ_DIS_BIT];
                if (cmp_en && pin_route) begin
                    if (vout_ff[g][`DCC_OD_BIT]) begin
                        nxt_out[g].open_drain = 1'b1;
                        nxt_out[g].pin_o      = 1'b0;
                        nxt_out[g].pin_oe     = ~cif.result;
                    end else begin
                        nxt_out[g].pin_o  = cif.result;
                        nxt_out[g].pin_oe = 1'b1;
                    end
                end else begin
                    nxt_out[g].analog_en = ~cmp_en;
                end
            end

            assign o_ref_sel[g]          = out_ff[g].ref_sel;
            assign o_gain_x2[g]          = out_ff[g].gain_x2;
            assign o_gain_invalid[g]     = out_ff[g].gain_bad;
            assign o_iout_range[g]       = out_ff[g].irange;
            assign o_iout_invalid[g]     = out_ff[g].irange_bad;
            assign o_cmp_mode_en[g]      = out_ff[g].cmp_en;
            assign o_fb_divider_en[g]    = out_ff[g].fb_div_en;
            assign o_hyst_en[g]          = out_ff[g].hyst_en;
            assign o_window_en[g]        = out_ff[g].window_en;
            assign o_cmp_mode_invalid[g] = out_ff[g].cmode_bad;
            assign o_cmp_result[g]       = cif.result;
            assign o_out_pin_o[g]        = out_ff[g].pin_o;
            assign o_out_pin_oe[g]       = out_ff[g].pin_oe;
            assign o_out_open_drain[g]   = out_ff[g].open_drain;
            assign o_out_analog_en[g]    = out_ff[g].analog_en;
        end
    endgenerate

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            out_ff <= '0;
        end else begin
            out_ff <= nxt_out;
        end
    end

endmodule : dcc_config_top

// File: dcc_config_checker.sv
`timescale 1ns/1ps

module dcc_config_checker (
    input wire logic            i_sys_clk,
    input wire logic            i_srst,
    input wire logic            i_reg_wr,
    input wire logic [7:0]      i_reg_addr,
    input wire logic [15:0]     i_reg_wdata,
    input wire logic [15:0]     o_reg_rdata,
    input wire logic            o_reg_ack,
    input wire logic [1:0]      o_cmp_mode_en,
    input wire logic [1:0]      o_fb_divider_en,
    input wire logic [1:0]      o_gain_invalid,
    input wire logic [1:0]      o_iout_invalid,
    input wire logic [1:0]      o_hyst_en,
    input wire logic [1:0]      o_window_en,
    input wire logic [1:0]      o_cmp_result,
    input wire logic [1:0]      o_out_pin_o,
    input wire logic [1:0]      o_out_pin_oe,
    input wire logic [1:0]      o_out_open_drain,
    input wire logic [1:0]      o_out_analog_en
);
    // ==================================================
    // properties
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);

    chk_gain_code_bad: assert property (
        i_reg_wr && i_reg_addr == 8'h15 |->
        ##2 o_gain_invalid[0] == ($past(i_reg_wdata[12:11], 2) == 2'h3))
        else $error("gain invalid flag wrong");
    chk_od_drive: assert property (
        (o_out_open_drain & (o_out_pin_o | o_out_analog_en)) == 2'h0)
        else $error("open drain drive wrong");
    chk_pin_follows: assert property (
        o_out_pin_oe[0] && !o_out_open_drain[0] |-> o_out_pin_o[0] == $past(o_cmp_result[0]))
        else $error("pin does not follow result");
    chk_fb_divider: assert property (
        i_reg_wr && i_reg_addr == 8'h03 |-> ##2 o_fb_divider_en[1] == $past(i_reg_wdata[2], 2))
        else $error("divider select wrong");
    chk_cmp_enable: assert property (
        i_reg_wr && i_reg_addr == 8'h15 |-> ##2 o_cmp_mode_en[0] == $past(i_reg_wdata[0], 2))
        else $error("comparator enable wrong");
    chk_result_off: assert property (
        !o_cmp_mode_en[0] && !$past(o_cmp_mode_en[0]) |-> !o_cmp_result[0])
        else $error("result active while disabled");
    chk_irange_bad: assert property (
        i_reg_wr && i_reg_addr == 8'h04 |->
        ##2 o_iout_invalid[1] == ($past(i_reg_wdata[12:11], 2) != 2'h2))
        else $error("current range flag wrong");
    chk_mode_decode: assert property (
        i_reg_wr && i_reg_addr == 8'h17 |->
        ##2 o_hyst_en[0] == ($past(i_reg_wdata[11:10], 2) == 2'h1)
        && o_window_en[0] == ($past(i_reg_wdata[11:10], 2) == 2'h2))
        else $error("threshold mode decode wrong");
    chk_reset_clear: assert property (
        $past(i_srst) |-> !o_reg_ack && o_cmp_mode_en == 2'h0 && o_out_pin_oe == 2'h0)
        else $error("outputs not cleared by reset");
    chk_rdata_mask: assert property (
        o_reg_ack |-> (o_reg_rdata & 16'hE1E0) == 16'h0000)
        else $error("unused bits read nonzero");
endmodule : dcc_config_checker

bind dcc_config_top dcc_config_checker u_chk (.i_sys_clk, .i_srst, .i_reg_wr, .i_reg_addr,
    .i_reg_wdata, .o_reg_rdata, .o_reg_ack, .o_cmp_mode_en, .o_fb_divider_en, .o_gain_invalid,
    .o_iout_invalid, .o_hyst_en, .o_window_en, .o_cmp_result, .o_out_pin_o, .o_out_pin_oe,
    .o_out_open_drain, .o_out_analog_en);

// File: tb_dac_channel_output_comparator_config.sv
`timescale 1ns/1ps

module tb_dac_channel_output_comparator_config;
    logic             i_sys_clk;
    logic             i_srst;
    logic             i_reg_wr;
    logic             i_reg_rd;
    logic [7:0]       i_reg_addr;
    logic [15:0]      i_reg_wdata;
    logic [15:0]      o_reg_rdata;
    logic             o_reg_ack;
    logic             o_reg_hit;
    logic [1:0][15:0] i_margin_high;
    logic [1:0][15:0] i_margin_low;
    logic [1:0][11:0] i_dac_code;
    logic [1:0][11:0] i_fb_code;
    logic [1:0][2:0]  o_ref_sel;
    logic [1:0][3:0]  o_gain_x2;
    logic [1:0][3:0]  o_iout_range;
    logic [1:0]       o_gain_invalid, o_iout_invalid, o_cmp_mode_en, o_fb_divider_en;
    logic [1:0]       o_hyst_en, o_window_en, o_cmp_mode_invalid, o_cmp_result;
    logic [1:0]       o_out_pin_o, o_out_pin_oe, o_out_open_drain, o_out_analog_en;
    int               n_mismatch;
    int               check_count;
    int               cycles;
    logic [7:0]       ad[6] = '{8'h03, 8'h04, 8'h05, 8'h15, 8'h16, 8'h17};
    logic [15:0]      mk[6] = '{16'h1C1F, 16'h1E00, 16'h0C00, 16'h1C1F, 16'h1E00, 16'h0C00};

    dcc_config_top #(.CODE_W(12)) uut (.i_sys_clk, .i_srst, .i_reg_wr, .i_reg_rd, .i_reg_addr,
        .i_reg_wdata, .o_reg_rdata, .o_reg_ack, .o_reg_hit, .i_margin_high, .i_margin_low,
        .i_dac_code, .i_fb_code, .o_ref_sel, .o_gain_x2, .o_gain_invalid, .o_iout_range,
        .o_iout_invalid, .o_cmp_mode_en, .o_fb_divider_en, .o_hyst_en, .o_window_en,
        .o_cmp_mode_invalid, .o_cmp_result, .o_out_pin_o, .o_out_pin_oe, .o_out_open_drain,
        .o_out_analog_en);

    // ==================================================
    // clock and timeout
    always #10 i_sys_clk = ~i_sys_clk;

    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end

    // ==================================================
    // shared tasks
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_sys_clk);
        i_reg_wr    <= 1'b1;
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        @(posedge i_sys_clk);
        i_reg_wr    <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [15:0] d, output logic h);
        @(posedge i_sys_clk);
        i_reg_rd   <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_sys_clk);
        i_reg_rd   <= 1'b0;
        #1;
        chk("ack", 16'h0001, o_reg_ack);
        d = o_reg_rdata;
        h = o_reg_hit;
    endtask : reg_rd

    task automatic settle();
        repeat (4) @(posedge i_sys_clk);
        #1;
    endtask : settle

    task automatic fb_chk(input logic [11:0] v, input logic r, input logic oe, input logic o);
        @(posedge i_sys_clk);
        i_fb_code[0] <= v;
        settle();
        chk("cmp_result", r, o_cmp_result[0]);
        chk("pin_oe", oe, o_out_pin_oe[0]);
        chk("pin_o", o, o_out_pin_o[0]);
    endtask : fb_chk

    function automatic logic [3:0] irange_exp(input logic [3:0] r);
        return (r[3:2] == 2'b10) ? (4'h1 << r[1:0]) : 4'h0;
    endfunction : irange_exp

    // ==================================================
    // scenarios
    task automatic t_reset();
        logic [15:0] d;
        logic        h;
        for (int i = 0; i < 6; i++) begin
            reg_rd(ad[i], d, h);
            chk("reset_rdata", 16'h0000, d);
            chk("hit", 16'h0001, h);
        end
        chk("ref_sel", 16'h0009, o_ref_sel);
        chk("gain_x2", 16'h0022, o_gain_x2);
        chk("cmp_en", 16'h0000, o_cmp_mode_en);
        chk("hyst", 16'h0000, o_hyst_en);
        chk("analog_en", 16'h0003, o_out_analog_en);
        $display("test reset done");
    endtask : t_reset

    task automatic t_gain();
        logic [3:0] gx[8] = '{4'h2, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'h0, 4'h0};
        logic [2:0] rf[8] = '{3'h1, 3'h2, 3'h4, 3'h4, 3'h4, 3'h4, 3'h0, 3'h0};
        logic [2:0] g;
        logic [2:0] h;
        for (int c = 0; c < 8; c++) begin
            g = c[2:0];
            h = ~g;
            reg_wr(8'h15, {3'h0, g, 10'h000});
            reg_wr(8'h03, {3'h0, h, 10'h000});
            settle();
            chk("gain0", gx[g], o_gain_x2[0]);
            chk("ref0", rf[g], o_ref_sel[0]);
            chk("gain_bad0", g[2] & g[1], o_gain_invalid[0]);
            chk("gain1", gx[h], o_gain_x2[1]);
            chk("ref1", rf[h], o_ref_sel[1]);
        end
        $display("test gain done");
    endtask : t_gain

    task automatic t_irange();
        logic [3:0] r;
        for (int c = 0; c < 16; c++) begin
            r = c[3:0];
            reg_wr(8'h04, {3'h0, r, 9'h000});
            reg_wr(8'h16, {3'h0, ~r, 9'h000});
            settle();
            chk("range1", irange_exp(r), o_iout_range[1]);
            chk("range_bad1", r[3:2] != 2'b10, o_iout_invalid[1]);
            chk("range0", irange_exp(~r), o_iout_range[0]);
        end
        $display("test current range done");
    endtask : t_irange

    task automatic t_mask();
        logic [15:0] d;
        logic        h;
        for (int i = 0; i < 6; i++) begin
            reg_wr(ad[i], 16'hFFFF);
            reg_rd(ad[i], d, h);
            chk("masked_rdata", mk[i], d);
        end
        reg_wr(8'h20, 16'hFFFF);
        reg_rd(8'h20, d, h);
        chk("unmapped_rdata", 16'h0000, d);
        chk("unmapped_hit", 16'h0000, h);
        for (int i = 0; i < 6; i++) reg_wr(ad[i], 16'h0000);
        $display("test mask done");
    endtask : t_mask

    task automatic t_cmp();
        logic [11:0] hv[5] = '{12'd200, 12'd350, 12'd300, 12'd50, 12'd200};
        logic        hr[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
        logic [11:0] wv[5] = '{12'd200, 12'd300, 12'd301, 12'd100, 12'd99};
        logic        wr[5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
        reg_wr(8'h15, 16'h0009);
        fb_chk(12'd250, 1'b1, 1'b1, 1'b1);
        fb_chk(12'd200, 1'b0, 1'b1, 1'b0);
        reg_wr(8'h15, 16'h000B);
        fb_chk(12'd200, 1'b1, 1'b1, 1'b1);
        reg_wr(8'h15, 16'h001B);
        fb_chk(12'd150, 1'b1, 1'b0, 1'b0);
        fb_chk(12'd250, 1'b0, 1'b1, 1'b0);
        chk("open_drain", 16'h0001, o_out_open_drain[0]);
        reg_wr(8'h15, 16'h0011);
        fb_chk(12'd250, 1'b1, 1'b0, 1'b0);
        chk("od_unrouted", 16'h0000, o_out_open_drain[0]);
        chk("analog_unrouted", 16'h0000, o_out_analog_en[0]);
        reg_wr(8'h15, 16'h0004);
        settle();
        chk("fb_div", 16'h0001, o_fb_divider_en[0]);
        chk("cmp_off", 16'h0000, o_cmp_mode_en[0]);
        chk("analog_on", 16'h0001, o_out_analog_en[0]);
        reg_wr(8'h17, 16'h0400);
        reg_wr(8'h15, 16'h0009);
        for (int i = 0; i < 5; i++) fb_chk(hv[i], hr[i], 1'b1, hr[i]);
        chk("hyst_en", 16'h0001, o_hyst_en[0]);
        reg_wr(8'h17, 16'h0800);
        for (int i = 0; i < 5; i++) fb_chk(wv[i], wr[i], 1'b1, wr[i]);
        chk("window_en", 16'h0001, o_window_en[0]);
        reg_wr(8'h17, 16'h0C00);
        settle();
        chk("mode_bad", 16'h0001, o_cmp_mode_invalid[0]);
        chk("mode_bad_hw", 16'h0000, {o_hyst_en[0], o_window_en[0]});
        reg_wr(8'h17, 16'h0000);
        settle();
        chk("mode_single", 16'h0000, {o_hyst_en[0], o_window_en[0], o_cmp_mode_invalid[0]});
        reg_wr(8'h15, 16'h0000);
        settle();
        chk("result_off", 16'h0000, o_cmp_result[0]);
        $display("test comparator done");
    endtask : t_cmp

    // ==================================================
    // main sequence
    initial begin
        i_sys_clk     = 1'b0;
        i_srst        = 1'b1;
        i_reg_wr      = 1'b0;
        i_reg_rd      = 1'b0;
        i_reg_addr    = 8'h00;
        i_reg_wdata   = 16'h0000;
        i_margin_high = {16'h12CF, 16'h12CF};
        i_margin_low  = {16'h064F, 16'h064F};
        i_dac_code    = {12'd200, 12'd200};
        i_fb_code     = {12'd0, 12'd0};
        n_mismatch    = 0;
        check_count   = 0;
        cycles        = 0;
        repeat (4) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        t_reset();
        t_gain();
        t_irange();
        t_mask();
        t_cmp();
        finish_test();
    end
endmodule : tb_dac_channel_output_comparator_config
